// [logic/bes_top.sv]
// Purpose: boot entry sequencer choosing loader or application after reset
// Assumes: port byte strobes are same-clock pulses from receivers
// Notes:   long waits use top parameters so simulation can shorten them
`timescale 1ns/100ps
`default_nettype none
module bes_top
  import bes_pkg::*;
#(
  parameter int unsigned XTAL_CYC    = XTAL_WAIT_CYC,
  parameter int unsigned PIN_CYC     = PIN_WAIT_CYC,
  parameter int unsigned TIMEOUT_LEN = TIMEOUT_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  vector_byte,
  input  wire logic [15:0] boot_enable_option,
  input  wire logic        readout_protection,
  input  wire logic        ext_clk_present,
  input  wire logic        uart_rx_valid,
  input  wire logic [7:0]  uart_rx_byte,
  input  wire logic        spi_rx_valid,
  input  wire logic [7:0]  spi_rx_byte,
  input  wire logic        can_rx_valid,
  input  wire logic [7:0]  can_rx_id,
  input  wire logic        baud_done,
  input  wire logic        cmd_valid,
  input  wire logic        go_cmd,
  input  wire logic [23:0] go_addr,
  output logic             irq_mask,
  output logic             internal_rc_osc_16m,
  output logic             external_crystal_osc_en,
  output logic             uart_pullup_en,
  output logic             spi_slave_en,
  output logic             uart_en,
  output logic             spi_en,
  output logic             can_en,
  output logic             can_rate_125k,
  output logic             baud_measure,
  output logic             cmd_wait,
  output logic             restore_regs,
  output logic             sw_reset,
  output logic             clear_ram_routines,
  output logic             jump_valid,
  output logic [23:0]      jump_addr,
  output logic [1:0]       active_port
);
  // ==========================================================
  // state
  bes_state_t  state_q;
  logic        empty_q;
  logic        loader_to_q;
  logic        uart_lock_q;
  logic [1:0]  port_q;
  logic        tmr_load;
  logic [31:0] tmr_val;
  logic        tmr_run;
  logic        tmr_done;
  logic        vec_ok;
  logic        uart_sync;
  logic        spi_sync;
  logic        can_sync;

  assign vec_ok    = (vector_byte == VEC_CODE_A) || (vector_byte == VEC_CODE_B);
  // a bad uart byte ends uart sync for good; spi and can may retry
  assign uart_sync = uart_rx_valid && uart_rx_byte == SYNC_CODE && !uart_lock_q;
  assign spi_sync  = spi_rx_valid && spi_rx_byte == SYNC_CODE;
  assign can_sync  = can_rx_valid && can_rx_id == SYNC_CODE && ext_clk_present;

  // ==========================================================
  // wait and timeout timer
  bes_timer u_timer (
    .clk      (clk),
    .rst      (rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .run      (tmr_run),
    .done     (tmr_done)
  );

  always_comb
  begin
    tmr_load = 1'b0;
    tmr_val  = 32'h0;
    case (state_q)
      ST_CHECK:
      begin
        tmr_load = 1'b1;
        tmr_val  = ext_clk_present ? XTAL_CYC : 32'h0;
      end
      ST_XTAL:
      begin
        tmr_load = tmr_done;
        tmr_val  = PIN_CYC;
      end
      ST_PINS:
      begin
        tmr_load = tmr_done;
        tmr_val  = TIMEOUT_LEN;
      end
      ST_POLL:
      begin
        tmr_load = uart_sync || spi_sync || can_sync;
        tmr_val  = TIMEOUT_LEN;
      end
      ST_BAUD:
      begin
        tmr_load = 1'b1;
        tmr_val  = TIMEOUT_LEN;
      end
      default:
      begin
        tmr_load = 1'b0;
        tmr_val  = 32'h0;
      end
    endcase
  end

  // the crystal wait doubles as a zero-length step when no crystal is fitted
  assign tmr_run = (state_q == ST_XTAL) || (state_q == ST_PINS) || (state_q == ST_POLL)
                 || (state_q == ST_CMD && loader_to_q);

  // ==========================================================
  // sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= ST_MASK;
    else
    begin
      case (state_q)
        ST_MASK:  state_q <= ST_CHECK;
        ST_CHECK:
        begin
          if (!vec_ok || boot_enable_option == BOOT_EN_PAT)
            state_q <= ST_XTAL;
          else
            state_q <= ST_APP;
        end
        ST_XTAL:  if (tmr_done) state_q <= ST_PINS;
        ST_PINS:  if (tmr_done) state_q <= ST_ROP;
        ST_ROP:   state_q <= readout_protection ? ST_RESTORE : ST_POLL;
        ST_POLL:
        begin
          if (uart_sync)
            state_q <= ST_BAUD;
          else if (spi_sync || can_sync)
            state_q <= ST_CMD;
          else if (tmr_done)
            state_q <= empty_q ? ST_SWRST : ST_RESTORE;
        end
        ST_BAUD:  if (baud_done) state_q <= ST_CMD;
        ST_CMD:
        begin
          if (cmd_valid && go_cmd)
            state_q <= ST_GO;
          else if (tmr_done && !cmd_valid)
            state_q <= ST_RESTORE;
        end
        ST_RESTORE: state_q <= ST_APP;
        ST_APP:     state_q <= ST_APP;
        ST_GO:      state_q <= ST_GO;
        ST_SWRST:   state_q <= ST_SWRST;
        default:    state_q <= ST_MASK;
      endcase
    end
  end

  // ==========================================================
  // entry decision flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      empty_q     <= 1'b0;
      loader_to_q <= 1'b0;
    end
    else if (state_q == ST_CHECK)
    begin
      empty_q     <= !vec_ok;
      loader_to_q <= vec_ok && boot_enable_option == BOOT_EN_PAT;
    end
    else if (state_q == ST_CMD && cmd_valid)
      loader_to_q <= 1'b0; // first command ends the loader timeout
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      uart_lock_q <= 1'b0;
    else if (state_q == ST_POLL && uart_rx_valid && uart_rx_byte != SYNC_CODE)
      uart_lock_q <= 1'b1;
  end

  // ==========================================================
  // port selection
  always_ff @(posedge clk)
  begin
    if (rst)
      port_q <= PORT_NONE;
    else if (state_q == ST_POLL)
    begin
      if (uart_sync)
        port_q <= PORT_UART;
      else if (spi_sync)
        port_q <= PORT_SPI;
      else if (can_sync)
        port_q <= PORT_CAN;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      jump_valid <= 1'b0;
      jump_addr  <= 24'h0;
    end
    else if (state_q == ST_RESTORE || (state_q == ST_CHECK && vec_ok
             && boot_enable_option != BOOT_EN_PAT))
    begin
      jump_valid <= 1'b1;
      jump_addr  <= APP_VECTOR;
    end
    else if (state_q == ST_CMD && cmd_valid && go_cmd)
    begin
      jump_valid <= 1'b1;
      jump_addr  <= go_addr;
    end
  end

  // ==========================================================
  // outputs
  logic polling;
  logic in_session;
  logic setup;
  assign polling    = (state_q == ST_POLL);
  assign in_session = (state_q == ST_BAUD) || (state_q == ST_CMD) || (state_q == ST_GO);
  assign setup      = (state_q == ST_XTAL) || (state_q == ST_PINS) || (state_q == ST_ROP);

  assign irq_mask                = 1'b1;
  assign internal_rc_osc_16m     = setup || polling || in_session;
  assign external_crystal_osc_en = (setup || polling || in_session) && ext_clk_present;
  assign uart_pullup_en          = setup || polling || in_session;
  assign spi_slave_en            = setup || polling || (in_session && port_q == PORT_SPI);
  assign uart_en = (polling && !uart_lock_q) || (in_session && port_q == PORT_UART);
  assign spi_en  = polling || (in_session && port_q == PORT_SPI);
  // can needs the external reference; the bus rate starts at 125 kbit/s
  assign can_en  = ext_clk_present && (polling || (in_session && port_q == PORT_CAN));
  assign can_rate_125k      = can_en;
  assign baud_measure       = (state_q == ST_BAUD);
  assign cmd_wait           = (state_q == ST_CMD);
  assign restore_regs       = (state_q == ST_RESTORE);
  assign sw_reset           = (state_q == ST_SWRST);
  assign clear_ram_routines = (state_q == ST_GO);
  assign active_port        = port_q;

  // ==========================================================
  // checks
  a_mask_first: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_CHECK |-> irq_mask) else $error("irq not masked at check");
  a_empty_loader: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_CHECK && !vec_ok |=> state_q == ST_XTAL) else $error("empty not loader");
  a_opt_jump: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_CHECK && vec_ok && boot_enable_option != BOOT_EN_PAT
    |=> jump_valid && jump_addr == APP_VECTOR) else $error("no app jump");
  a_rop_exit: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_ROP && readout_protection |=> ##1 jump_valid) else $error("rop ignored");
  a_can_clock: assert property (@(posedge clk) disable iff (rst)
    can_en |-> ext_clk_present) else $error("can without clock");
  a_uart_lock: assert property (@(posedge clk) disable iff (rst)
    polling && uart_rx_valid && uart_rx_byte != SYNC_CODE |=> !uart_en) else $error("uart lock");
  a_spi_retry: assert property (@(posedge clk) disable iff (rst)
    polling && spi_rx_valid && spi_rx_byte != SYNC_CODE && !uart_sync && !can_sync && !tmr_done
    |=> polling) else $error("spi retry lost");
  a_one_port: assert property (@(posedge clk) disable iff (rst)
    in_session |-> $onehot0({uart_en, spi_en, can_en})) else $error("extra port");
  a_empty_swrst: assert property (@(posedge clk) disable iff (rst)
    polling && tmr_done && empty_q && !uart_sync && !spi_sync && !can_sync
    |=> sw_reset) else $error("no soft reset");
  a_prio_uart: assert property (@(posedge clk) disable iff (rst)
    polling && uart_sync && spi_sync |=> port_q == PORT_UART) else $error("priority");
  c_uart_sess: cover property (@(posedge clk) disable iff (rst) baud_measure ##[1:20] cmd_wait);
  c_go: cover property (@(posedge clk) disable iff (rst) clear_ram_routines);
  c_timeout: cover property (@(posedge clk) disable iff (rst) restore_regs);
  c_swrst: cover property (@(posedge clk) disable iff (rst) sw_reset);
endmodule
`default_nettype wire

// [include/bes_pkg.sv]
// Purpose: shared constants and types for the boot entry sequencer
// Assumes: 100 MHz clock
// Notes:   timing counts derive from the printed times
`default_nettype none
package bes_pkg;
  localparam int unsigned CLK_HZ        = 100000000;
  localparam int unsigned XTAL_WAIT_US  = 6000;
  localparam int unsigned PIN_WAIT_US   = 4000;
  localparam int unsigned TIMEOUT_MS    = 1000;
  localparam int unsigned XTAL_WAIT_CYC = XTAL_WAIT_US * (CLK_HZ / 1000000);
  localparam int unsigned PIN_WAIT_CYC  = PIN_WAIT_US * (CLK_HZ / 1000000);
  localparam int unsigned TIMEOUT_CYC   = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam logic [7:0]  VEC_CODE_A    = 8'h82;
  localparam logic [7:0]  VEC_CODE_B    = 8'hac;
  localparam logic [15:0] BOOT_EN_PAT   = 16'h55aa;
  localparam logic [7:0]  SYNC_CODE     = 8'h7f;
  localparam logic [23:0] APP_VECTOR    = 24'h008000;
  localparam logic [7:0]  RAM_ROUT_BASE = 8'ha0;
  localparam logic [1:0]  PORT_UART     = 2'h0;
  localparam logic [1:0]  PORT_SPI      = 2'h1;
  localparam logic [1:0]  PORT_CAN      = 2'h2;
  localparam logic [1:0]  PORT_NONE     = 2'h3;
  typedef enum logic [3:0] {
    ST_MASK, ST_CHECK, ST_XTAL, ST_PINS, ST_ROP, ST_POLL,
    ST_BAUD, ST_CMD, ST_RESTORE, ST_APP, ST_GO, ST_SWRST
  } bes_state_t;
endpackage
`default_nettype wire

// [logic/bes_timer.sv]
// Purpose: down counter for settle waits and timeouts
// Assumes: load and run from the same clock domain
// Notes:   done is a level while count is zero and running
`timescale 1ns/100ps
`default_nettype none
module bes_timer
  import bes_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  input  wire logic        run,
  output logic             done
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= 32'h0;
    else if (load)
      cnt_q <= load_val;
    else if (run && cnt_q != 32'h0)
      cnt_q <= cnt_q - 32'h1;
  end

  // done must not look at load: the sequencer builds load from done
  assign done = run && (cnt_q == 32'h0);
endmodule
`default_nettype wire

// [bench/bes_host.sv]
// Purpose: programming host model driving the serial sync strobes
// Assumes: strobes are one-cycle pulses set on the falling edge
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/100ps
`default_nettype none
module bes_host
  import bes_pkg::*;
#(
  parameter int SETTLE = 40
)
(
  input  wire logic clk,
  input  wire logic rst,
  output logic      uart_rx_valid,
  output logic [7:0] uart_rx_byte,
  output logic      spi_rx_valid,
  output logic [7:0] spi_rx_byte,
  output logic      can_rx_valid,
  output logic [7:0] can_rx_id
);
  int age;
  always_ff @(posedge clk) age <= rst ? 0 : age + 1;
  initial
  begin
    {uart_rx_valid, spi_rx_valid, can_rx_valid} = 3'h0;
    {uart_rx_byte, spi_rx_byte, can_rx_id} = 24'h0;
  end
  // =========
  // send one byte on every port set in m
  task automatic send(input logic [2:0] m, input logic [7:0] b);
    while (age < SETTLE) @(negedge clk);
    @(negedge clk);
    {can_rx_valid, spi_rx_valid, uart_rx_valid} = m;
    {uart_rx_byte, spi_rx_byte, can_rx_id} = {3{b}};
    @(negedge clk);
    {uart_rx_valid, spi_rx_valid, can_rx_valid} = 3'h0;
    {uart_rx_byte, spi_rx_byte, can_rx_id} = {3{~b}};
  endtask
endmodule
`default_nettype wire

// [bench/tb_bes_top.sv]
// Purpose: self-checking bench for the boot entry sequencer
// Assumes: settle and timeout counts shortened by parameters
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
module tb_bes_top
  import bes_pkg::*;
;
  localparam int XC = 20;
  localparam int PC = 20;
  localparam int TL = 100;
  logic clk, rst, ro, ext, bd, cv, gc, rr_seen;
  logic [7:0] vb;
  logic [15:0] bo;
  logic [23:0] ga, a;
  logic uv, sv, nv, irq, rc, xo, pu, ss, ue, se, ce, cr, bm, cw, rr, sw, cl, jv;
  logic [7:0] ub, sb, cb;
  logic [23:0] ja;
  logic [1:0] ap;
  int n_fail, samples_checked, seed, waited;
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  bes_top #(.XTAL_CYC(XC), .PIN_CYC(PC), .TIMEOUT_LEN(TL)) DUT (
    .clk(clk), .rst(rst), .vector_byte(vb), .boot_enable_option(bo),
    .readout_protection(ro), .ext_clk_present(ext), .uart_rx_valid(uv),
    .uart_rx_byte(ub), .spi_rx_valid(sv), .spi_rx_byte(sb), .can_rx_valid(nv),
    .can_rx_id(cb), .baud_done(bd), .cmd_valid(cv), .go_cmd(gc), .go_addr(ga),
    .irq_mask(irq), .internal_rc_osc_16m(rc), .external_crystal_osc_en(xo),
    .uart_pullup_en(pu), .spi_slave_en(ss), .uart_en(ue), .spi_en(se),
    .can_en(ce), .can_rate_125k(cr), .baud_measure(bm), .cmd_wait(cw),
    .restore_regs(rr), .sw_reset(sw), .clear_ram_routines(cl),
    .jump_valid(jv), .jump_addr(ja), .active_port(ap));
  bes_host #(.SETTLE(XC + PC + 4)) host (
    .clk(clk), .rst(rst), .uart_rx_valid(uv), .uart_rx_byte(ub),
    .spi_rx_valid(sv), .spi_rx_byte(sb), .can_rx_valid(nv), .can_rx_id(cb));
  // =========
  // helpers
  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  function automatic logic [7:0] rb(input logic [7:0] x, input logic [7:0] y);
    logic [7:0] v;
    v = 8'($random(seed));
    return (v == x || v == y) ? ~x & ~y : v;
  endfunction
  function automatic logic [15:0] ropt();
    logic [15:0] v;
    v = 16'($random(seed));
    return (v == BOOT_EN_PAT) ? 16'h0000 : v;
  endfunction
  function automatic bit sig(input int s);
    case (s)
      0: return ue === 1'b1;
      1: return cw === 1'b1;
      2: return jv === 1'b1;
      3: return sw === 1'b1;
      default: return bm === 1'b1;
    endcase
  endfunction
  task automatic wt(input int s, input int lim, input string m);
    waited = 0;
    rr_seen = 0;
    while (!sig(s) && waited < lim)
    begin
      @(negedge clk);
      if (rr === 1'b1) rr_seen = 1;
      waited++;
    end
    chk(sig(s), m);
  endtask
  task automatic boot(input logic [7:0] v, input logic [15:0] o, input logic r, input logic e);
    @(negedge clk);
    rst = 1;
    {vb, bo, ro, ext, bd, cv, gc} = {v, o, r, e, 3'h0};
    repeat (4) @(negedge clk);
    rst = 0;
  endtask
  // =========
  // scenarios
  initial
  begin
    #200000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    seed = 32'hbfe8;
    {n_fail, samples_checked} = 0;
    {rst, ro, ext, bd, cv, gc, vb, bo, ga} = {1'b1, 5'h0, 48'h0};
    repeat (4)
    begin
      boot(seed[0] ? VEC_CODE_A : VEC_CODE_B, ropt(), 0, 0);
      wt(2, 5, "no app jump");
      chk(ja === APP_VECTOR && ue === 1'b0 && irq === 1'b1, "app start bad");
    end
    boot(rb(VEC_CODE_A, VEC_CODE_B), ropt(), 0, 0);
    wt(0, XC + PC + 10, "no poll");
    chk(waited > PC && rc === 1'b1 && pu === 1'b1 && ss === 1'b1 && xo === 1'b0, "setup bad");
    host.send(3'b001, rb(SYNC_CODE, SYNC_CODE));
    host.send(3'b001, SYNC_CODE);
    host.send(3'b100, SYNC_CODE);
    repeat (3) @(negedge clk);
    chk(ap === PORT_NONE && bm === 1'b0 && ce === 1'b0, "sync taken");
    host.send(3'b010, rb(SYNC_CODE, SYNC_CODE));
    host.send(3'b010, SYNC_CODE);
    wt(1, 3, "spi sync lost");
    chk(ap === PORT_SPI && ue === 1'b0 && ce === 1'b0, "others on");
    repeat (TL + 20) @(negedge clk);
    chk(cw === 1'b1 && jv === 1'b0, "empty store timed out");
    {ga, gc, cv} = {16'h0, RAM_ROUT_BASE, 2'b01};
    @(negedge clk);
    chk(cw === 1'b1 && jv === 1'b0, "plain command left loader");
    a = 24'($random(seed));
    {ga, gc, cv} = {a, 2'b11};
    @(negedge clk);
    {ga, gc, cv} = {~a, 2'b00};
    wt(2, 3, "no go");
    chk(ja === a && cl === 1'b1, "go bad");
    boot(rb(VEC_CODE_A, VEC_CODE_B), ropt(), 0, 1);
    wt(0, XC + PC + 10, "no poll");
    chk(waited >= XC + PC && ce === 1'b1 && cr === 1'b1 && xo === 1'b1, "can setup");
    host.send(3'b011, SYNC_CODE);
    wt(4, 3, "no baud");
    chk(ap === PORT_UART && cw === 1'b0 && se === 1'b0, "bad pick");
    bd = 1;
    @(negedge clk);
    bd = 0;
    wt(1, 3, "no cmd wait");
    boot(rb(VEC_CODE_A, VEC_CODE_B), ropt(), 0, 0);
    wt(3, XC + PC + TL + 20, "no sw reset");
    chk(jv === 1'b0 && waited > TL, "empty jumped");
    boot(VEC_CODE_B, BOOT_EN_PAT, 0, 0);
    wt(2, XC + PC + TL + 20, "no app after poll");
    chk(rr_seen === 1'b1 && ja === APP_VECTOR, "restore bad");
    boot(VEC_CODE_A, BOOT_EN_PAT, 0, 1);
    wt(0, XC + PC + 10, "no poll");
    host.send(3'b100, rb(SYNC_CODE, SYNC_CODE));
    host.send(3'b100, SYNC_CODE);
    wt(1, 3, "can sync lost");
    chk(ap === PORT_CAN && bm === 1'b0, "can pick");
    wt(2, TL + 20, "no cmd timeout");
    chk(ja === APP_VECTOR && waited >= TL, "timeout target");
    boot(VEC_CODE_A, BOOT_EN_PAT, 1, 0);
    wt(2, XC + PC + 20, "protected kept loader");
    chk(ja === APP_VECTOR && cw === 1'b0, "protected target");
    end_of_test();
  end
endmodule
`default_nettype wire
